// ### common/jtp_params.svh
// Purpose: Constants for the boundary-scan test access port
// Assumes: Included by bare name from design files
// Notes:   Instruction and data register layout of the port
`ifndef JTP_PARAMS_SVH
`define JTP_PARAMS_SVH

// Instruction register
`define JTP_IR_W          4
`define JTP_IR_CAPTURE    4'h1
`define JTP_INS_EXTEST    4'h0
`define JTP_INS_IDCODE    4'h1
`define JTP_INS_BYPASS    4'hF

// Identification register; value is arbitrary
`define JTP_ID_W          32
`define JTP_ID_VALUE      32'h1234_5671

// Synchroniser depth for pin inputs
`define JTP_SYNC_STAGES   2

`endif

// ### common/jtp_pkg.sv
// Purpose: Types for the boundary-scan test access port
// Assumes: Used by scoped name only
// Notes:   Sixteen controller states, encoded 0 to 15 in declaration order
package jtp_pkg;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } jtp_state_t;

endpackage

// ### src/jtp_sync.sv
// Purpose: Two-stage synchroniser for one pin input
// Assumes: Input is asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps

module jtp_sync
#(
    parameter logic INIT = 1'b1         // Value held after reset
)
(
    input  wire logic clk,              // System clock
    input  wire logic rst,              // Synchronous reset, active high
    input  wire logic ce,               // Clock enable
    input  wire logic pinIn,            // Asynchronous input
    output logic      syncOut           // Synchronised copy
);

    logic meta_q;

    // Two flip-flops in series
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q  <= INIT;
            syncOut <= INIT;
        end
        else if (ce)
        begin
            meta_q  <= pinIn;
            syncOut <= meta_q;
        end
    end

endmodule

// ### src/jtp_tap_port.sv
// Purpose: Boundary-scan test access port, oversampling the test clock
// Assumes: clk at 40 MHz, test clock at most an eighth of that
// Notes:   Test reset acts asynchronously on all controller state
// How it works
// R1 - Mode select is taken on each rising test clock edge.
// R2 - Serial data input is taken on each rising edge into the chosen path.
// R3 - Serial data output changes only on falling test clock edges.
// R4 - Data output is high impedance except while a scan path is shifting.
// R5 - Active-low test reset resets the port at once, without clock edges.
// R6 - Controller follows the sixteen-state boundary-scan state machine.
`timescale 1ns/1ps
`include "jtp_params.svh"

module jtp_tap_port
(
    input  wire logic                  clk,        // System clock, 40 MHz
    input  wire logic                  rst,        // Synchronous reset, active high
    input  wire logic                  ce,         // Clock enable, freezes state
    input  wire logic                  tck,        // Test clock pin
    input  wire logic                  tms,        // Test mode select pin
    input  wire logic                  tdi,        // Test data input pin
    input  wire logic                  trstN,      // Test reset pin, active low
    output logic                       tdoOut,     // Test data output value
    output logic                       tdoOe,      // Test data output enable
    output logic [`JTP_IR_W-1:0]       irValue,    // Active instruction
    output logic                       tapInReset  // Controller in reset state
);

    jtp_pkg::jtp_state_t state_q;
    jtp_pkg::jtp_state_t state_d;

    logic                  tckS;
    logic                  tmsS;
    logic                  tdiS;
    logic                  tckPrev_q;
    logic [`JTP_IR_W-1:0]  irShift_q;
    logic [`JTP_ID_W-1:0]  idShift_q;
    logic                  bypass_q;

    // Pin synchronisers
    jtp_sync #(.INIT(1'b0)) uSyncTck (.clk(clk), .rst(rst), .ce(ce), .pinIn(tck), .syncOut(tckS));
    jtp_sync #(.INIT(1'b1)) uSyncTms (.clk(clk), .rst(rst), .ce(ce), .pinIn(tms), .syncOut(tmsS));
    jtp_sync #(.INIT(1'b1)) uSyncTdi (.clk(clk), .rst(rst), .ce(ce), .pinIn(tdi), .syncOut(tdiS));

    // Test clock edge detection
    wire tckRise = ce & tckS & ~tckPrev_q;
    wire tckFall = ce & ~tckS & tckPrev_q;

    // Path selection decode
    wire inShiftDr = (state_q == jtp_pkg::SHIFT_DR);
    wire inShiftIr = (state_q == jtp_pkg::SHIFT_IR);
    wire inShift   = inShiftDr | inShiftIr;
    wire selId     = (irValue == `JTP_INS_IDCODE);
    wire drBit     = selId ? idShift_q[0] : bypass_q;
    wire shiftBit  = inShiftIr ? irShift_q[0] : drBit;

    assign tapInReset = (state_q == jtp_pkg::TEST_LOGIC_RESET);

    // Edge history of the test clock
    always_ff @(posedge clk)
    begin
        if (rst)
            tckPrev_q <= 1'b0;
        else if (ce)
            tckPrev_q <= tckS;
    end

    // Next state from mode select
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            jtp_pkg::TEST_LOGIC_RESET: state_d = tmsS ? jtp_pkg::TEST_LOGIC_RESET
                                                      : jtp_pkg::RUN_TEST_IDLE;
            jtp_pkg::RUN_TEST_IDLE:    state_d = tmsS ? jtp_pkg::SELECT_DR
                                                      : jtp_pkg::RUN_TEST_IDLE;
            jtp_pkg::SELECT_DR:        state_d = tmsS ? jtp_pkg::SELECT_IR
                                                      : jtp_pkg::CAPTURE_DR;
            jtp_pkg::CAPTURE_DR:       state_d = tmsS ? jtp_pkg::EXIT1_DR
                                                      : jtp_pkg::SHIFT_DR;
            jtp_pkg::SHIFT_DR:         state_d = tmsS ? jtp_pkg::EXIT1_DR
                                                      : jtp_pkg::SHIFT_DR;
            jtp_pkg::EXIT1_DR:         state_d = tmsS ? jtp_pkg::UPDATE_DR
                                                      : jtp_pkg::PAUSE_DR;
            jtp_pkg::PAUSE_DR:         state_d = tmsS ? jtp_pkg::EXIT2_DR
                                                      : jtp_pkg::PAUSE_DR;
            jtp_pkg::EXIT2_DR:         state_d = tmsS ? jtp_pkg::UPDATE_DR
                                                      : jtp_pkg::SHIFT_DR;
            jtp_pkg::UPDATE_DR:        state_d = tmsS ? jtp_pkg::SELECT_DR
                                                      : jtp_pkg::RUN_TEST_IDLE;
            jtp_pkg::SELECT_IR:        state_d = tmsS ? jtp_pkg::TEST_LOGIC_RESET
                                                      : jtp_pkg::CAPTURE_IR;
            jtp_pkg::CAPTURE_IR:       state_d = tmsS ? jtp_pkg::EXIT1_IR
                                                      : jtp_pkg::SHIFT_IR;
            jtp_pkg::SHIFT_IR:         state_d = tmsS ? jtp_pkg::EXIT1_IR
                                                      : jtp_pkg::SHIFT_IR;
            jtp_pkg::EXIT1_IR:         state_d = tmsS ? jtp_pkg::UPDATE_IR
                                                      : jtp_pkg::PAUSE_IR;
            jtp_pkg::PAUSE_IR:         state_d = tmsS ? jtp_pkg::EXIT2_IR
                                                      : jtp_pkg::PAUSE_IR;
            jtp_pkg::EXIT2_IR:         state_d = tmsS ? jtp_pkg::UPDATE_IR
                                                      : jtp_pkg::SHIFT_IR;
            jtp_pkg::UPDATE_IR:        state_d = tmsS ? jtp_pkg::SELECT_DR
                                                      : jtp_pkg::RUN_TEST_IDLE;
            default:                   state_d = jtp_pkg::TEST_LOGIC_RESET;
        endcase
    end

    // Controller state, advanced on rising test clock edges
    always_ff @(posedge clk or negedge trstN)
    begin
        if (!trstN)
            state_q <= jtp_pkg::TEST_LOGIC_RESET;    // [R5]
        else if (rst)
            state_q <= jtp_pkg::TEST_LOGIC_RESET;
        else if (tckRise)
            state_q <= state_d;                      // [R1] [R6]
    end

    // Instruction path: capture, shift, update
    always_ff @(posedge clk or negedge trstN)
    begin
        if (!trstN)
        begin
            irShift_q <= `JTP_IR_CAPTURE;             // [R5]
            irValue   <= `JTP_INS_IDCODE;
        end
        else if (rst)
        begin
            irShift_q <= `JTP_IR_CAPTURE;
            irValue   <= `JTP_INS_IDCODE;
        end
        else if (tckRise)
        begin
            if (state_q == jtp_pkg::CAPTURE_IR)
                irShift_q <= `JTP_IR_CAPTURE;
            else if (inShiftIr)
                irShift_q <= {tdiS, irShift_q[`JTP_IR_W-1:1]};  // [R2]
            if (state_q == jtp_pkg::UPDATE_IR)
                irValue <= irShift_q;
            else if (tapInReset)
                irValue <= `JTP_INS_IDCODE;
        end
    end

    // Data paths: identification and bypass
    always_ff @(posedge clk or negedge trstN)
    begin
        if (!trstN)
        begin
            idShift_q <= `JTP_ID_VALUE;              // [R5]
            bypass_q  <= 1'b0;
        end
        else if (rst)
        begin
            idShift_q <= `JTP_ID_VALUE;
            bypass_q  <= 1'b0;
        end
        else if (tckRise)
        begin
            if (state_q == jtp_pkg::CAPTURE_DR)
            begin
                idShift_q <= `JTP_ID_VALUE;
                bypass_q  <= 1'b0;
            end
            else if (inShiftDr)
            begin
                if (selId)
                    idShift_q <= {tdiS, idShift_q[`JTP_ID_W-1:1]};  // [R2]
                else
                    bypass_q <= tdiS;                              // [R2]
            end
        end
    end

    // Data output, moved only on falling edges, enabled while shifting
    always_ff @(posedge clk or negedge trstN)
    begin
        if (!trstN)
        begin
            tdoOut <= 1'b0;
            tdoOe  <= 1'b0;                          // [R5]
        end
        else if (rst)
        begin
            tdoOut <= 1'b0;
            tdoOe  <= 1'b0;
        end
        else if (tckFall)
        begin
            tdoOut <= inShift ? shiftBit : 1'b0;     // [R3]
            tdoOe  <= inShift;                       // [R4]
        end
    end

    // Checks
    a_tms_idle_hold: assert property (@(posedge clk) disable iff (rst || !trstN)  // [R1]
        (tckRise && state_q == jtp_pkg::RUN_TEST_IDLE && !tmsS)
            |=> state_q == jtp_pkg::RUN_TEST_IDLE)
        else $error("Idle state left with mode select low");

    a_tdi_bypass_take: assert property (@(posedge clk) disable iff (rst || !trstN)  // [R2]
        (tckRise && inShiftDr && !selId) |=> bypass_q == $past(tdiS))
        else $error("Bypass bit did not take data input");

    // Test reset may move the output off any edge, so samples taken in reset are skipped
    a_tdo_on_fall: assert property (@(posedge clk) disable iff (rst || !trstN)  // [R3]
        (trstN && (tdoOut != $past(tdoOut) || tdoOe != $past(tdoOe)))
            |-> $past(tckFall))
        else $error("Data output changed away from a falling edge");

    a_tdo_enable_shift: assert property (@(posedge clk) disable iff (rst || !trstN)  // [R4]
        $rose(tdoOe) |-> $past(tckFall && inShift))
        else $error("Data output enabled outside a shift state");

    a_trst_forces_reset: assert property (@(posedge clk) disable iff (rst)  // [R5]
        !trstN |-> (tapInReset && !tdoOe && irValue == `JTP_INS_IDCODE))
        else $error("Test reset did not reset the port");

    a_tap_reset_walk: assert property (@(posedge clk) disable iff (rst || !trstN)  // [R6]
        (tckRise && state_q == jtp_pkg::SELECT_IR && tmsS)
            |=> state_q == jtp_pkg::TEST_LOGIC_RESET)
        else $error("Select-IR with mode select high missed reset");

    a_tap_update_idle: assert property (@(posedge clk) disable iff (rst || !trstN)  // [R6]
        (tckRise && state_q == jtp_pkg::UPDATE_DR && !tmsS)
            |=> state_q == jtp_pkg::RUN_TEST_IDLE ##1 !tckRise [*1])
        else $error("Update-DR did not return to idle");

endmodule

// ### tb/jtp_ctrl_model.sv
// Purpose: Behavioural boundary-scan controller that drives the test port pins
// Assumes: One test clock period spans eight clk cycles, 200 ns
// Notes:   Test clock stands low between steps; lines change only while it is low
`timescale 1ns/1ps

module jtp_ctrl_model
(
    input  wire logic clk,      // Bench clock
    input  wire logic tdo,      // Resolved test data output wire
    output logic      tck,      // Test clock
    output logic      tms,      // Mode select
    output logic      tdi       // Test data in
);
    // Idle levels: clock low, pulled-up lines high
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One test clock period; q is taken at the rise, hold says it stayed put while high
    task automatic step(input logic m, input logic d, output logic q, output logic hold);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        repeat (3) @(posedge clk);
        tck <= 1'b1;
        q = tdo;
        repeat (4) @(posedge clk);
        hold = (tdo === q);
        tck <= 1'b0;
    endtask
endmodule

// ### tb/jtp_tap_port_bench.sv
// Purpose: Self-checking bench for the boundary-scan test access port
// Assumes: Controller model drives the test pins; ce drops only in the freeze scenario
// Notes:   Scan values go LSB first; the data output wire floats while disabled
`timescale 1ns/1ps
`include "jtp_params.svh"

module jtp_tap_port_bench;
    logic                 clk;
    logic                 rst;
    logic                 ce;
    logic                 trstN;
    logic                 tck;
    logic                 tms;
    logic                 tdi;
    logic                 tdoOut;
    logic                 tdoOe;
    logic                 tapInReset;
    logic [`JTP_IR_W-1:0] irValue;
    int                   badCount;
    int                   nTests;
    wire                  tdo = tdoOe ? tdoOut : 1'bz;

    jtp_tap_port DUT (.clk(clk), .rst(rst), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
        .trstN(trstN), .tdoOut(tdoOut), .tdoOe(tdoOe), .irValue(irValue),
        .tapInReset(tapInReset));
    jtp_ctrl_model ctrl (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

    // Clock source
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            badCount++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Compares %0d, mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One test clock period plus a check that the output held during the high phase
    task automatic go(input logic m, input logic d, output logic q);
        logic hold;
        ctrl.step(m, d, q, hold);
        check("tdo steady while tck high", hold, 1'b1);
    endtask

    // Walks the controller with n mode bits, LSB first
    task automatic walk(input logic [7:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++)
            go(seq[i], 1'b1, q);
    endtask

    // Shifts n bits; the last one leaves the shift state
    task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        for (int i = 0; i < n; i++)
        begin
            go(i == n - 1, din[i], q);
            dout[i] = q;
        end
    endtask

    task automatic t_reset();
        check("reset state", tapInReset, 1'b1);
        check("reset instruction", irValue, 4'h1);
        check("reset output enable", tdoOe, 1'b0);
    endtask

    task automatic t_ident();
        logic [31:0] d;
        walk(8'h02, 4);
        shift(32, 32'h0000_0000, d);
        check("identification bits", d, `JTP_ID_VALUE);
        walk(8'h01, 2);
        check("tdo idle after scan", tdoOe, 1'b0);
    endtask

    task automatic t_bypass();
        logic [31:0] d;
        walk(8'h03, 4);
        shift(4, 32'h0000_000F, d);
        check("instruction capture", d[3:0], 4'h1);
        walk(8'h01, 2);
        check("instruction loaded", irValue, 4'hF);
        walk(8'h01, 3);
        shift(8, 32'h0000_00A5, d);
        check("bypass delay", d[7:0], 8'h4A);
        walk(8'h01, 2);
    endtask

    task automatic t_async();
        walk(8'h01, 3);
        repeat (4) @(posedge clk);
        check("output on in shift", tdoOe, 1'b1);
        trstN <= 1'b0;
        #2;
        check("async reset state", tapInReset, 1'b1);
        check("async reset enable", tdoOe, 1'b0);
        check("async reset instruction", irValue, 4'h1);
        @(posedge clk);
        trstN <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic t_five_ones();
        walk(8'h02, 4);
        check("left reset state", tapInReset, 1'b0);
        walk(8'h1F, 4);
        check("four ones not enough", tapInReset, 1'b0);
        walk(8'h01, 1);
        check("five ones reset", tapInReset, 1'b1);
    endtask

    // A test clock pulse while ce is low must leave the controller where it was
    task automatic t_freeze();
        logic q;
        ce <= 1'b0;
        go(1'b0, 1'b1, q);
        check("frozen state", tapInReset, 1'b1);
        ce <= 1'b1;
        go(1'b0, 1'b1, q);
        check("enabled state", tapInReset, 1'b0);
    endtask

    // Main sequence
    initial
    begin
        badCount = 0;
        nTests = 0;
        rst = 1'b1;
        ce = 1'b1;
        trstN = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_ident();
        t_bypass();
        t_async();
        t_five_ones();
        t_freeze();
        finish_test();
    end

    // Watchdog, well beyond the roughly 15 us the scenarios need
    initial
    begin
        #200us;
        badCount++;
        finish_test();
    end
endmodule
